/* File: common/rtc_defs.vh */
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// register indices; byte address is four times the index
`define IDX_SECONDS 22'h0FFF92
`define IDX_MINUTES 22'h0FFF93
`define IDX_WEEKDAY 22'h0FFF95
`define IDX_DAY 22'h0FFF96
`define IDX_MONTH 22'h0FFF97
`define IDX_YEAR 22'h0FFF98
`define IDX_MAIN_CTRL 22'h0FFF9D
`define IDX_ALARM_WAIT 22'h0FFF9E
`define IDX_HOURS 22'h0FFFA0

// reset values
`define RST_SECONDS 8'h00
`define RST_MINUTES 8'h00
`define RST_HOURS 8'h12
`define RST_DAY 8'h01
`define RST_WEEKDAY 8'h00
`define RST_MONTH 8'h01
`define RST_YEAR 8'h00
`define RST_CTRL 8'h00

// write masks of the count registers
`define MASK_SECONDS 8'h7F
`define MASK_MINUTES 8'h7F
`define MASK_HOURS 8'h3F
`define MASK_DAY 8'h3F
`define MASK_WEEKDAY 8'h07
`define MASK_MONTH 8'h1F
`define MASK_YEAR 8'hFF

// alarm_wait_control bit positions
`define BIT_ALARM_MATCH_ENABLE 7
`define BIT_ALARM_IRQ_ENABLE 6
`define BIT_ALARM_MATCH_FLAG 4
`define BIT_PERIODIC_EVENT_FLAG 3
`define BIT_HOLD_STATUS 1
`define BIT_HOLD_REQUEST 0

// clock_main_control bit positions
`define BIT_COUNT_RUN 7
`define BIT_HOUR_FORMAT_SELECT 3
`define PERIOD_SEL_HI 2
`define PERIOD_SEL_LO 0

// periodic event selections
`define PER_NONE 3'h0
`define PER_HALF 3'h1
`define PER_SECOND 3'h2
`define PER_MINUTE 3'h3
`define PER_HOUR 3'h4
`define PER_DAY 3'h5

// sub-second overflow value, 16 bits
`define SUBSEC_TOP 16'h7FFF

// bcd limits
`define BCD_59 8'h59
`define BCD_23 8'h23
`define BCD_12 8'h12
`define BCD_11 8'h11
`define BCD_32 8'h32
`define BCD_31 8'h31
`define BCD_30 8'h30
`define BCD_29 8'h29
`define BCD_28 8'h28
`define BCD_01 8'h01
`define BCD_00 8'h00
`define WEEK_LAST 8'h06

`endif

/* File: hdl/rtc_subsec_counter.v */
`include "rtc_defs.vh"

module rtc_subsec_counter #(
  parameter [15:0] TOP = `SUBSEC_TOP
) (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire clear_i,
  output wire ovf_o,
  output wire half_o
);
  reg [15:0] cnt_q;

  // keeps running through hold, only count_run stops it
  assign ovf_o = run_i & ~clear_i & (cnt_q == TOP);
  assign half_o = run_i & ~clear_i & (cnt_q == (TOP >> 1));

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
    end else if (clear_i) begin
      cnt_q <= 16'h0000;
    end else if (run_i) begin
      cnt_q <= ovf_o ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
endmodule

/* File: hdl/rtc_hour_format.v */
`include "rtc_defs.vh"

module rtc_hour_format (
  input wire [7:0] hour_i,
  input wire to_24_i,
  output reg [7:0] hour_o
);
  reg [4:0] bin;
  reg [4:0] b12;

  function [4:0] bcd2bin;
    input [7:0] v;
    begin
      bcd2bin = {1'b0, v[3:0]} + (v[4] ? 5'd10 : 5'd0);
    end
  endfunction

  function [7:0] bin2bcd;
    input [4:0] v;
    reg [4:0] t20;
    reg [4:0] t10;
    begin
      t20 = v - 5'd20;
      t10 = v - 5'd10;
      if (v >= 5'd20) begin
        bin2bcd = {4'h2, t20[3:0]};
      end else if (v >= 5'd10) begin
        bin2bcd = {4'h1, t10[3:0]};
      end else begin
        bin2bcd = {4'h0, v[3:0]};
      end
    end
  endfunction

  always @* begin
    bin = 5'd0;
    b12 = 5'd0;
    if (to_24_i) begin
      bin = bcd2bin({3'b000, hour_i[4:0]});
      if (bin == 5'd12) begin
        bin = 5'd0;
      end
      if (hour_i[5]) begin
        bin = bin + 5'd12;
      end
      hour_o = bin2bcd(bin);
    end else begin
      bin = bcd2bin(hour_i);
      b12 = (bin >= 5'd12) ? bin - 5'd12 : bin;
      if (b12 == 5'd0) begin
        b12 = 5'd12;
      end
      hour_o = bin2bcd(b12) | ((bin >= 5'd12) ? 8'h20 : 8'h00);
    end
  end
endmodule

/* File: hdl/rtc_time_counter_chain.v */
// Decided for this implementation: register access over Wishbone.
`include "rtc_defs.vh"

module rtc_time_counter_chain #(
  parameter [15:0] SUBSEC_TOP = `SUBSEC_TOP
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [23:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire alarm_hit_i,
  output reg calendar_irq_o,
  output reg [7:0] minutes_o,
  output reg [7:0] hours_o,
  output reg [7:0] weekday_o
);
  localparam [2:0] F_SEC = 3'd0;
  localparam [2:0] F_MIN = 3'd1;
  localparam [2:0] F_HOUR = 3'd2;
  localparam [2:0] F_DAY = 3'd3;
  localparam [2:0] F_WEEK = 3'd4;
  localparam [2:0] F_MONTH = 3'd5;
  localparam [2:0] F_YEAR = 3'd6;

  reg [7:0] sec_q;
  reg [7:0] min_q;
  reg [7:0] hour_q;
  reg [7:0] day_q;
  reg [7:0] week_q;
  reg [7:0] month_q;
  reg [7:0] year_q;
  reg count_run_q;
  reg hour_format_select_q;
  reg [2:0] period_sel_q;
  reg alarm_match_enable_q;
  reg alarm_irq_enable_q;
  reg alarm_match_flag_q;
  reg periodic_event_flag_q;
  reg hold_request_q;
  reg hold_status_q;
  reg pend_ovf_q;
  reg alarm_seen_q;
  reg wbuf_pend_q;
  reg [2:0] wbuf_field_q;
  reg [7:0] wbuf_val_q;
  reg fmt_chg_q;

  wire [21:0] idx = adr_i[23:2];
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire bus_wr = bus_req & we_i & sel_i[0];
  wire [7:0] wdat = dat_i[7:0];

  function [7:0] bcd_inc;
    input [7:0] v;
    reg [3:0] hi;
    reg [3:0] lo;
    begin
      hi = v[7:4] + 4'h1;
      lo = v[3:0] + 4'h1;
      if (v[3:0] == 4'h9) begin
        bcd_inc = {hi, 4'h0};
      end else begin
        bcd_inc = {v[7:4], lo};
      end
    end
  endfunction

  function is_leap;
    input [7:0] y;
    begin
      if (y[4]) begin
        is_leap = (y[3:0] == 4'h2) | (y[3:0] == 4'h6);
      end else begin
        is_leap = (y[3:0] == 4'h0) | (y[3:0] == 4'h4) | (y[3:0] == 4'h8);
      end
    end
  endfunction

  function [7:0] last_day;
    input [7:0] m;
    input leap;
    begin
      case (m)
        8'h04, 8'h06, 8'h09, 8'h11: last_day = `BCD_30;
        8'h02: last_day = leap ? `BCD_29 : `BCD_28;
        default: last_day = `BCD_31;
      endcase
    end
  endfunction

  function wr_hits;
    input pend;
    input [2:0] f;
    input [2:0] want;
    begin
      wr_hits = pend & (f == want);
    end
  endfunction

  // buffered write strobes, one per field
  wire w_sec = wr_hits(wbuf_pend_q, wbuf_field_q, F_SEC);
  wire w_min = wr_hits(wbuf_pend_q, wbuf_field_q, F_MIN);
  wire w_hour = wr_hits(wbuf_pend_q, wbuf_field_q, F_HOUR);
  wire w_day = wr_hits(wbuf_pend_q, wbuf_field_q, F_DAY);
  wire w_week = wr_hits(wbuf_pend_q, wbuf_field_q, F_WEEK);
  wire w_month = wr_hits(wbuf_pend_q, wbuf_field_q, F_MONTH);
  wire w_year = wr_hits(wbuf_pend_q, wbuf_field_q, F_YEAR);

  wire ovf;
  wire half;

  rtc_subsec_counter #(
    .TOP(SUBSEC_TOP)
  ) u_subsec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(count_run_q),
    .clear_i(w_sec),
    .ovf_o(ovf),
    .half_o(half)
  );

  wire [7:0] hour_conv;

  rtc_hour_format u_fmt (
    .hour_i(hour_q),
    .to_24_i(hour_format_select_q),
    .hour_o(hour_conv)
  );

  // carry chain, all combinational so a rollover lands in one tick
  wire running = count_run_q & ~hold_request_q;
  wire sec_tick = running & (ovf | pend_ovf_q) & ~w_sec;
  wire sec_wrap = (sec_q == `BCD_59);
  wire min_tick = sec_tick & sec_wrap & ~w_min;
  wire min_wrap = (min_q == `BCD_59);
  wire hour_tick = min_tick & min_wrap & ~w_hour & ~fmt_chg_q;
  wire hour_wrap = hour_format_select_q ? (hour_q == `BCD_23) : (hour_q == `BCD_31);
  wire day_tick = hour_tick & hour_wrap & ~w_day;
  wire day_wrap = (day_q == last_day(month_q, is_leap(year_q)));
  wire week_tick = hour_tick & hour_wrap & ~w_week;
  wire month_tick = day_tick & day_wrap & ~w_month;
  wire month_wrap = (month_q == `BCD_12);
  wire year_tick = month_tick & month_wrap & ~w_year;

  reg [7:0] hour_next;

  always @* begin
    hour_next = bcd_inc(hour_q);
    if (hour_format_select_q) begin
      if (hour_wrap) begin
        hour_next = `BCD_00;
      end
    end else begin
      case (hour_q)
        `BCD_12: hour_next = `BCD_01;
        `BCD_11: hour_next = `BCD_32;
        `BCD_32: hour_next = 8'h21;
        `BCD_31: hour_next = `BCD_12;
        default: hour_next = bcd_inc(hour_q);
      endcase
    end
  end

  reg periodic_evt;

  always @* begin
    case (period_sel_q)
      `PER_NONE: periodic_evt = 1'b0;
      `PER_HALF: periodic_evt = sec_tick | (running & half);
      `PER_SECOND: periodic_evt = sec_tick;
      `PER_MINUTE: periodic_evt = min_tick;
      `PER_HOUR: periodic_evt = hour_tick;
      `PER_DAY: periodic_evt = day_tick;
      default: periodic_evt = month_tick;
    endcase
  end

  // time counters
  always @(posedge clk_i) begin
    if (rst_i) begin
      sec_q <= `RST_SECONDS;
      min_q <= `RST_MINUTES;
      hour_q <= `RST_HOURS;
      day_q <= `RST_DAY;
      week_q <= `RST_WEEKDAY;
      month_q <= `RST_MONTH;
      year_q <= `RST_YEAR;
    end else begin
      if (w_sec) begin
        sec_q <= wbuf_val_q;
      end else if (sec_tick) begin
        sec_q <= sec_wrap ? `BCD_00 : bcd_inc(sec_q);
      end
      if (w_min) begin
        min_q <= wbuf_val_q;
      end else if (min_tick) begin
        min_q <= min_wrap ? `BCD_00 : bcd_inc(min_q);
      end
      if (fmt_chg_q) begin
        hour_q <= hour_conv;
      end else if (w_hour) begin
        hour_q <= wbuf_val_q;
      end else if (hour_tick) begin
        hour_q <= hour_next;
      end
      if (w_day) begin
        day_q <= wbuf_val_q;
      end else if (day_tick) begin
        day_q <= day_wrap ? `BCD_01 : bcd_inc(day_q);
      end
      if (w_week) begin
        week_q <= wbuf_val_q;
      end else if (week_tick) begin
        week_q <= (week_q == `WEEK_LAST) ? 8'h00 : week_q + 8'h01;
      end
      if (w_month) begin
        month_q <= wbuf_val_q;
      end else if (month_tick) begin
        month_q <= month_wrap ? `BCD_01 : bcd_inc(month_q);
      end
      if (w_year) begin
        year_q <= wbuf_val_q;
      end else if (year_tick) begin
        year_q <= (year_q == 8'h99) ? `BCD_00 : bcd_inc(year_q);
      end
    end
  end

  // write buffer; the bus cannot issue two writes closer than two cycles
  reg buf_load;
  reg [2:0] buf_field;
  reg [7:0] buf_mask;

  always @* begin
    buf_load = bus_wr;
    buf_field = F_SEC;
    buf_mask = `MASK_SECONDS;
    case (idx)
      `IDX_SECONDS: begin
        buf_field = F_SEC;
        buf_mask = `MASK_SECONDS;
      end
      `IDX_MINUTES: begin
        buf_field = F_MIN;
        buf_mask = `MASK_MINUTES;
      end
      `IDX_HOURS: begin
        buf_field = F_HOUR;
        buf_mask = `MASK_HOURS;
      end
      `IDX_DAY: begin
        buf_field = F_DAY;
        buf_mask = `MASK_DAY;
      end
      `IDX_WEEKDAY: begin
        buf_field = F_WEEK;
        buf_mask = `MASK_WEEKDAY;
      end
      `IDX_MONTH: begin
        buf_field = F_MONTH;
        buf_mask = `MASK_MONTH;
      end
      `IDX_YEAR: begin
        buf_field = F_YEAR;
        buf_mask = `MASK_YEAR;
      end
      default: buf_load = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wbuf_pend_q <= 1'b0;
      wbuf_field_q <= F_SEC;
      wbuf_val_q <= 8'h00;
    end else begin
      wbuf_pend_q <= buf_load;
      if (buf_load) begin
        wbuf_field_q <= buf_field;
        wbuf_val_q <= wdat & buf_mask;
      end
    end
  end

  // hold handshake and remembered overflow
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_status_q <= 1'b0;
      pend_ovf_q <= 1'b0;
    end else begin
      hold_status_q <= hold_request_q;
      if (w_sec) begin
        pend_ovf_q <= 1'b0;
      end else if (count_run_q & hold_request_q & ovf) begin
        pend_ovf_q <= 1'b1;
      end else if (sec_tick) begin
        pend_ovf_q <= 1'b0;
      end
    end
  end

  // control and status bits; a hardware set wins over a software clear
  wire wr_aw = bus_wr & (idx == `IDX_ALARM_WAIT);
  wire wr_mc = bus_wr & (idx == `IDX_MAIN_CTRL);

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_run_q <= 1'b0;
      hour_format_select_q <= 1'b0;
      period_sel_q <= `PER_NONE;
      fmt_chg_q <= 1'b0;
      alarm_match_enable_q <= 1'b0;
      alarm_irq_enable_q <= 1'b0;
      hold_request_q <= 1'b0;
      alarm_match_flag_q <= 1'b0;
      periodic_event_flag_q <= 1'b0;
      alarm_seen_q <= 1'b0;
      calendar_irq_o <= 1'b0;
    end else begin
      fmt_chg_q <= wr_mc & (wdat[`BIT_HOUR_FORMAT_SELECT] != hour_format_select_q);
      if (wr_mc) begin
        count_run_q <= wdat[`BIT_COUNT_RUN];
        hour_format_select_q <= wdat[`BIT_HOUR_FORMAT_SELECT];
        period_sel_q <= wdat[`PERIOD_SEL_HI:`PERIOD_SEL_LO];
      end
      if (wr_aw) begin
        alarm_match_enable_q <= wdat[`BIT_ALARM_MATCH_ENABLE];
        alarm_irq_enable_q <= wdat[`BIT_ALARM_IRQ_ENABLE];
        hold_request_q <= wdat[`BIT_HOLD_REQUEST];
      end
      alarm_seen_q <= alarm_hit_i & alarm_match_enable_q;
      if (alarm_seen_q) begin
        alarm_match_flag_q <= 1'b1;
      end else if (wr_aw & ~wdat[`BIT_ALARM_MATCH_FLAG]) begin
        alarm_match_flag_q <= 1'b0;
      end
      if (periodic_evt) begin
        periodic_event_flag_q <= 1'b1;
      end else if (wr_aw & ~wdat[`BIT_PERIODIC_EVENT_FLAG]) begin
        periodic_event_flag_q <= 1'b0;
      end
      // one pulse shared by both causes; flags tell them apart
      calendar_irq_o <= periodic_evt | (alarm_seen_q & alarm_irq_enable_q);
    end
  end

  // read mux and acknowledge; unmapped reads return zero
  reg [7:0] rd;

  always @* begin
    case (idx)
      `IDX_SECONDS: rd = sec_q;
      `IDX_MINUTES: rd = min_q;
      `IDX_HOURS: rd = hour_q;
      `IDX_DAY: rd = day_q;
      `IDX_WEEKDAY: rd = week_q;
      `IDX_MONTH: rd = month_q;
      `IDX_YEAR: rd = year_q;
      `IDX_MAIN_CTRL: rd = {count_run_q, 3'b000, hour_format_select_q, period_sel_q};
      `IDX_ALARM_WAIT: rd = {alarm_match_enable_q, alarm_irq_enable_q, 1'b0,
                             alarm_match_flag_q, periodic_event_flag_q, 1'b0,
                             hold_status_q, hold_request_q};
      default: rd = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      minutes_o <= `RST_MINUTES;
      hours_o <= `RST_HOURS;
      weekday_o <= `RST_WEEKDAY;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? {24'h00_0000, rd} : 32'h0000_0000;
      minutes_o <= min_q;
      hours_o <= hour_q;
      weekday_o <= week_q;
    end
  end
endmodule

/* File: dv/rtc_chain_asserts.sv */
module rtc_chain_asserts #(
  parameter [15:0] SUBSEC_TOP = 16'h7FFF
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [23:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire alarm_hit_i,
  input wire calendar_irq_o,
  input wire [7:0] minutes_o,
  input wire [7:0] hours_o,
  input wire [7:0] weekday_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // writes may move any field, so carry relations are only judged well after one
  logic [2:0] since_wr_q;
  wire quiet = (since_wr_q == 3'h4);
  always @(posedge clk_i) begin
    if (rst_i || (ack_o && we_i)) since_wr_q <= 3'h0;
    else if (!quiet) since_wr_q <= since_wr_q + 3'h1;
  end
  chk_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_rdata_idle: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data without ack");
  chk_min_bcd: assert property (minutes_o[7:4] <= 4'h5 && minutes_o[3:0] <= 4'h9)
    else $error("minutes out of bcd range");
  chk_week_range: assert property (weekday_o <= 8'h06)
    else $error("weekday above six");
  chk_hour_digits: assert property (hours_o[7:6] == 2'h0 && hours_o[3:0] <= 4'h9)
    else $error("hours not bcd");
  chk_min_step: assert property (quiet && $changed(minutes_o) && $past(minutes_o) != 8'h59 |->
    minutes_o == $past(minutes_o) + (($past(minutes_o[3:0]) == 4'h9) ? 8'h07 : 8'h01))
    else $error("minutes did not step by one");
  chk_min_wrap: assert property (quiet && $changed(minutes_o) && $past(minutes_o) == 8'h59
    |-> minutes_o == 8'h00)
    else $error("minutes did not wrap to zero");
  chk_hour_carry: assert property (quiet && $changed(hours_o) |-> minutes_o == 8'h00)
    else $error("hours moved without minute carry");
  chk_week_carry: assert property (quiet && $changed(weekday_o) |->
    minutes_o == 8'h00 && (hours_o == 8'h00 || hours_o == 8'h12))
    else $error("weekday moved off midnight");
endmodule

bind rtc_time_counter_chain rtc_chain_asserts #(.SUBSEC_TOP(SUBSEC_TOP)) u_rtc_chain_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .alarm_hit_i(alarm_hit_i),
  .calendar_irq_o(calendar_irq_o), .minutes_o(minutes_o), .hours_o(hours_o),
  .weekday_o(weekday_o));

/* File: dv/rtc_time_counter_chain_tb.sv */
`include "rtc_defs.vh"
module rtc_time_counter_chain_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, alarm_hit_i = 0;
  logic [23:0] adr_i = 24'h000000;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o, calendar_irq_o;
  logic [7:0] minutes_o, hours_o, weekday_o, rd;
  int fails = 0, checks_done = 0, cycles = 0;
  // eight cycles per second keeps every rollover short
  rtc_time_counter_chain #(.SUBSEC_TOP(16'h0007)) u_rtc_time_counter_chain (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .alarm_hit_i(alarm_hit_i),
    .calendar_irq_o(calendar_irq_o), .minutes_o(minutes_o), .hours_o(hours_o),
    .weekday_o(weekday_o));
  initial forever #4 clk_i = ~clk_i;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [21:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
  endtask
  task automatic rdchk(input logic [21:0] idx, input logic [7:0] exp);
    wb(idx, 0, 8'h00);
    check(rd, exp);
  endtask
  task automatic reset_values;
    rdchk(`IDX_SECONDS, 8'h00);
    rdchk(`IDX_MINUTES, 8'h00);
    rdchk(`IDX_WEEKDAY, 8'h00);
    rdchk(`IDX_DAY, 8'h01);
    rdchk(`IDX_ALARM_WAIT, 8'h00);
    rdchk(`IDX_HOURS, 8'h12);
    rdchk(22'h0FFF99, 8'h00); // unmapped index reads zero
  endtask
  task automatic hour_format;
    wb(`IDX_MAIN_CTRL, 1, 8'h08);
    rdchk(`IDX_HOURS, 8'h00);
    wb(`IDX_HOURS, 1, 8'h13);
    wb(`IDX_MAIN_CTRL, 1, 8'h00);
    rdchk(`IDX_HOURS, 8'h21);
    wb(`IDX_HOURS, 1, 8'h32);
    wb(`IDX_MAIN_CTRL, 1, 8'h08);
    rdchk(`IDX_HOURS, 8'h12);
  endtask
  task automatic roll(input logic [7:0] fmt, h, y, m, d, eh, ed, em, ew);
    wb(`IDX_MAIN_CTRL, 1, fmt);
    wb(`IDX_YEAR, 1, y);
    wb(`IDX_MONTH, 1, m);
    wb(`IDX_DAY, 1, d);
    wb(`IDX_WEEKDAY, 1, 8'h06);
    wb(`IDX_HOURS, 1, h);
    wb(`IDX_MINUTES, 1, 8'h59);
    wb(`IDX_SECONDS, 1, 8'h59);
    wb(`IDX_MAIN_CTRL, 1, fmt | 8'h80);
    do @(posedge clk_i); while (minutes_o !== 8'h00);
    wb(`IDX_MAIN_CTRL, 1, fmt);
    check({hours_o, weekday_o}, {eh, ew});
    rdchk(`IDX_SECONDS, 8'h00);
    rdchk(`IDX_DAY, ed);
    rdchk(`IDX_MONTH, em);
  endtask
  task automatic hold_overflow;
    wb(`IDX_MAIN_CTRL, 1, 8'h80);
    wb(`IDX_ALARM_WAIT, 1, 8'h19);
    rdchk(`IDX_ALARM_WAIT, 8'h03);
    wb(`IDX_SECONDS, 1, 8'h10);
    rdchk(`IDX_SECONDS, 8'h10);
    repeat (6) @(posedge clk_i);
    // one sub-second overflow has now passed inside hold
    wb(`IDX_ALARM_WAIT, 1, 8'h18);
    rdchk(`IDX_SECONDS, 8'h11);
    wb(`IDX_ALARM_WAIT, 1, 8'h19);
    repeat (12) @(posedge clk_i);
    wb(`IDX_SECONDS, 1, 8'h20);
    wb(`IDX_ALARM_WAIT, 1, 8'h18);
    rdchk(`IDX_SECONDS, 8'h20);
    wb(`IDX_MAIN_CTRL, 1, 8'h00);
  endtask
  task automatic flags;
    wb(`IDX_MAIN_CTRL, 1, 8'h82);
    do @(posedge clk_i); while (calendar_irq_o !== 1'b1);
    wb(`IDX_MAIN_CTRL, 1, 8'h02);
    rdchk(`IDX_ALARM_WAIT, 8'h08);
    wb(`IDX_ALARM_WAIT, 1, 8'h10);
    rdchk(`IDX_ALARM_WAIT, 8'h00);
    wb(`IDX_MAIN_CTRL, 1, 8'h80);
    wb(`IDX_ALARM_WAIT, 1, 8'h40);
    @(posedge clk_i);
    alarm_hit_i <= 1;
    repeat (4) @(posedge clk_i);
    alarm_hit_i <= 0;
    rdchk(`IDX_ALARM_WAIT, 8'h40);
    wb(`IDX_ALARM_WAIT, 1, 8'hC0);
    @(posedge clk_i);
    alarm_hit_i <= 1;
    @(posedge clk_i);
    // sample between edges so the launching edge cannot race the look
    @(negedge clk_i);
    check(calendar_irq_o, 1'b0);
    @(negedge clk_i);
    check(calendar_irq_o, 1'b1);
    @(posedge clk_i);
    alarm_hit_i <= 0;
    rdchk(`IDX_ALARM_WAIT, 8'hD0);
    wb(`IDX_ALARM_WAIT, 1, 8'hC8);
    rdchk(`IDX_ALARM_WAIT, 8'hC0);
    wb(`IDX_MAIN_CTRL, 1, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    reset_values;
    hour_format;
    roll(8'h00, 8'h11, 8'h00, 8'h01, 8'h15, 8'h32, 8'h15, 8'h01, 8'h06);
    roll(8'h00, 8'h31, 8'h00, 8'h01, 8'h31, 8'h12, 8'h01, 8'h02, 8'h00);
    roll(8'h00, 8'h31, 8'h04, 8'h02, 8'h28, 8'h12, 8'h29, 8'h02, 8'h00);
    roll(8'h00, 8'h31, 8'h01, 8'h02, 8'h28, 8'h12, 8'h01, 8'h03, 8'h00);
    roll(8'h00, 8'h31, 8'h00, 8'h04, 8'h30, 8'h12, 8'h01, 8'h05, 8'h00);
    roll(8'h08, 8'h23, 8'h00, 8'h01, 8'h10, 8'h00, 8'h11, 8'h01, 8'h00);
    hold_overflow;
    flags;
    end_of_test;
  end
endmodule
